/* File: msc_pkg.sv */
// What this block does
// - Base and extension audio layers carry identical time stamps on matching units.
// - SNR layers and two data partitions share exactly the same presentation times.
// - Spatial layers with equal frame rates share presentation times; else maximise common ones.
// - Spatial prediction uses latest, latest I/P, or second I/P unless low delay.
// - Temporal enhancement references coincident/previous or next lower picture by presentation time.
// - Buffer scale and size fields in first packet per stream and on change.
// - First pack holds system header; headers follow pack header and never differ (only val0 is compared, within one stream).
// - Constrained stream at low rate bound delivers at most 300 packets per second.
// - Above threshold, packet count per pack scales with peak rate of 400 times bound.
// - Rate interval spans pack to next pack, or to the stream end code.
// - Constrained stream audio input buffer never exceeds 4096 bytes.
// - Constrained stream video buffer is verifier size plus a bounded extra amount.
// - Clock to audio sample rate ratio is exactly 27 MHz over nominal rate.
// - Clock to picture rate ratio equals the tabled constant for each nominal rate.
// - Picture rate ratios are exact integers, so fractional nominal rates are approximate.
// - First access unit of every elementary stream carries a presentation time stamp.
package msc_pkg;

   // ***********************************************************
   // Stream and field sizes
   // ***********************************************************
   localparam int SID_W    = 3;
   localparam int NSTREAM  = 8;
   localparam int TS_W     = 33;
   localparam int AUX_W    = 24;
   localparam int BUF_W    = 24;
   localparam int NP_W     = 16;
   localparam int WIDE_W   = 80;
   localparam int RATIO_W  = 64;

   // ***********************************************************
   // Timing and limit constants
   // ***********************************************************
   localparam logic [WIDE_W-1:0]  SCR_HZ       = 80'd90000;     // Time stamp tick rate
   localparam logic [WIDE_W-1:0]  PKT_PER_S    = 80'd300;
   localparam logic [WIDE_W-1:0]  THR_FLAG_HI  = 80'd4500000;
   localparam logic [WIDE_W-1:0]  THR_FLAG_LO  = 80'd2000000;
   localparam logic [WIDE_W-1:0]  RMAX_MUL     = 80'd400;       // 8 bits times 50 byte/s units
   localparam logic [TS_W-1:0]    AUD_BUF_MAX  = 33'd4096;
   localparam logic [TS_W-1:0]    VID_ADD_MAX  = 33'd1024;
   localparam logic [RATIO_W-1:0] SYS_CLK_HZ   = 64'd27000000;

   // ***********************************************************
   // Reference choice codes
   // ***********************************************************
   localparam logic [1:0] REF_LATEST    = 2'h0;
   localparam logic [1:0] REF_LATEST_IP = 2'h1;
   localparam logic [1:0] REF_SECOND_IP = 2'h2;
   localparam logic [1:0] REF_ILLEGAL   = 2'h3;

   // ***********************************************************
   // Violation flag positions
   // ***********************************************************
   localparam int V_LAYER    = 0;
   localparam int V_SPATIAL  = 1;
   localparam int V_TEMPORAL = 2;
   localparam int V_BUFFLD   = 3;
   localparam int V_SYSFIRST = 4;
   localparam int V_SYSPLACE = 5;
   localparam int V_SYSDIFF  = 6;
   localparam int V_PKTRATE  = 7;
   localparam int V_AUDBUF   = 8;
   localparam int V_VIDBUF   = 9;
   localparam int V_AUDCLK   = 10;
   localparam int V_VIDCLK   = 11;
   localparam int V_FIRSTPTS = 12;
   localparam int V_ORDER    = 13;
   localparam int NVIOL      = 14;

   typedef enum logic [3:0] {
      EV_PACK, EV_SYS, EV_PES, EV_END, EV_LAYER,
      EV_SPATIAL, EV_TEMPORAL, EV_AUDCLK, EV_VIDCLK
   } msc_kind_type;

   typedef enum logic {ST_IDLE, ST_RATE} msc_state_type;

   // One stream event; meaning of fields depends on kind
   typedef struct packed {
      msc_kind_type     kind;
      logic [SID_W-1:0] sid;
      logic             audio;
      logic             f_a;
      logic             f_b;
      logic             f_c;
      logic [TS_W-1:0]  val0;
      logic [TS_W-1:0]  val1;
      logic [AUX_W-1:0] aux;
   } msc_event_type;

endpackage : msc_pkg

/* File: msc_fifo.sv */
`timescale 1ns/1ps
module msc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [CW-1:0]    count_q;
   logic [CW-1:0]    count_d;
   logic             ready_q;
   logic             push;
   logic             pop;

   // ***********************************************************
   // Handshakes and occupancy
   // ***********************************************************
   assign push      = in_valid & ready_q;
   assign pop       = out_valid & out_ready;
   assign out_valid = count_q != '0;
   assign out_data  = mem[rd_q];
   assign in_ready  = ready_q;
   assign count_d   = count_q + CW'(push) - CW'(pop);

   // Storage has no reset; only the pointers matter
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // Ready is registered so the source sees a clean level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q    <= '0;
         rd_q    <= '0;
         count_q <= '0;
         ready_q <= 1'b0;
      end else begin
         wr_q    <= push ? ((wr_q == LAST) ? '0 : wr_q + AW'(1)) : wr_q;
         rd_q    <= pop ? ((rd_q == LAST) ? '0 : rd_q + AW'(1)) : rd_q;
         count_q <= count_d;
         ready_q <= count_d != FULL;
      end
   end

endmodule : msc_fifo

/* File: msc_checker.sv */
`timescale 1ns/1ps
module msc_checker #(
   parameter int DEPTH = 16
) (
   input  wire logic                      clk,
   input  wire logic                      resetn,
   input  wire logic                      ev_valid,
   input  wire msc_pkg::msc_event_type    ev_data,
   output logic                           ev_ready,
   input  wire logic                      clear_viol,
   output logic [msc_pkg::NVIOL-1:0]      viol,
   output logic                           csps,
   output logic                           done
);
   localparam int EW = $bits(msc_pkg::msc_event_type);
   localparam int NS = msc_pkg::NSTREAM;

   // ***********************************************************
   // Nominal rate lookups
   // ***********************************************************
   // Audio codes 0..5 map to 16, 22.05, 24, 32, 44.1, 48 kHz
   function automatic logic [15:0] audio_hz(input logic [2:0] code);
      unique case (code)
         3'h0:    audio_hz = 16'd16000;
         3'h1:    audio_hz = 16'd22050;
         3'h2:    audio_hz = 16'd24000;
         3'h3:    audio_hz = 16'd32000;
         3'h4:    audio_hz = 16'd44100;
         3'h5:    audio_hz = 16'd48000;
         default: audio_hz = 16'h0000;
      endcase
   endfunction : audio_hz

   // Exact clock ticks per picture; the fractional rates are thus approximations
   function automatic logic [20:0] ticks_per_pic(input logic [2:0] code);
      unique case (code)
         3'h0: ticks_per_pic = 21'd1126125;
         3'h1: ticks_per_pic = 21'd1125000;
         3'h2: ticks_per_pic = 21'd1080000;
         3'h3: ticks_per_pic = 21'd900900;
         3'h4: ticks_per_pic = 21'd900000;
         3'h5: ticks_per_pic = 21'd540000;
         3'h6: ticks_per_pic = 21'd450450;
         3'h7: ticks_per_pic = 21'd450000;
      endcase
   endfunction : ticks_per_pic

   // ***********************************************************
   // Input buffer
   // ***********************************************************
   logic          f_valid;
   logic          f_ready;
   logic [EW-1:0] f_data;
   msc_pkg::msc_event_type ev;

   msc_fifo #(
      .WIDTH (EW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (ev_valid),
      .in_data   (ev_data),
      .in_ready  (ev_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_ready)
   );

   assign ev = msc_pkg::msc_event_type'(f_data);

   // ***********************************************************
   // State
   // ***********************************************************
   msc_pkg::msc_state_type            state_q;
   logic [msc_pkg::NVIOL-1:0]         viol_q;
   logic [msc_pkg::NVIOL-1:0]         set_v;
   logic                              done_q;
   logic                              csps_q;
   logic                              restrict_q;
   logic [21:0]                       rate_bound_q;
   logic                              have_pack_q;
   logic                              first_pack_q;
   logic                              sys_first_q;
   logic                              after_hdr_q;
   logic                              sys_valid_q;
   logic [msc_pkg::TS_W-1:0]          sys_val_q;
   logic [msc_pkg::TS_W-1:0]          scr_q;
   logic [msc_pkg::NP_W-1:0]          np_q;
   logic [msc_pkg::WIDE_W-1:0]        lhs_q;
   logic [msc_pkg::WIDE_W-1:0]        rhs_q;
   logic [NS-1:0]                     seen_q;
   logic [NS-1:0]                     pts_seen_q;
   logic [msc_pkg::BUF_W-1:0]         buf_q [NS];

   // ***********************************************************
   // Event decode
   // ***********************************************************
   logic                          take;
   logic                          is_pack;
   logic                          is_sys;
   logic                          is_pes;
   logic                          is_end;
   logic                          is_layer;
   logic                          is_spat;
   logic                          is_temp;
   logic                          is_aclk;
   logic                          is_vclk;
   logic                          is_bad;
   logic                          pack_edge;
   logic                          rate_due;
   logic                          np_inc;
   logic                          pes_seen;
   logic                          pes_pts_seen;
   logic [msc_pkg::BUF_W-1:0]     pes_buf;
   logic [msc_pkg::TS_W-1:0]      dt;
   logic [msc_pkg::WIDE_W-1:0]    thr;
   logic [msc_pkg::WIDE_W-1:0]    rmax;
   logic [msc_pkg::WIDE_W-1:0]    lim;
   logic [msc_pkg::WIDE_W-1:0]    lhs_d;
   logic [msc_pkg::WIDE_W-1:0]    rhs_d;
   logic [msc_pkg::RATIO_W-1:0]   aud_lhs;
   logic [msc_pkg::RATIO_W-1:0]   aud_rhs;
   logic [msc_pkg::RATIO_W-1:0]   vid_rhs;
   logic [15:0]                   aud_nom;
   logic [msc_pkg::TS_W-1:0]      vid_lim;

   // Stall the buffer while a packet rate comparison is pending
   assign f_ready  = state_q == msc_pkg::ST_IDLE;
   assign take     = f_valid & f_ready;
   assign is_pack  = ev.kind == msc_pkg::EV_PACK;
   assign is_sys   = ev.kind == msc_pkg::EV_SYS;
   assign is_pes   = ev.kind == msc_pkg::EV_PES;
   assign is_end   = ev.kind == msc_pkg::EV_END;
   assign is_layer = ev.kind == msc_pkg::EV_LAYER;
   assign is_spat  = ev.kind == msc_pkg::EV_SPATIAL;
   assign is_temp  = ev.kind == msc_pkg::EV_TEMPORAL;
   assign is_aclk  = ev.kind == msc_pkg::EV_AUDCLK;
   assign is_vclk  = ev.kind == msc_pkg::EV_VIDCLK;
   assign is_bad   = ~(is_pack | is_sys | is_pes | is_end | is_layer | is_spat | is_temp | is_aclk | is_vclk);

   assign pack_edge    = take & (is_pack | is_end);
   assign np_inc       = take & (is_pes | is_sys) & (np_q != '1);
   assign pes_seen     = seen_q[ev.sid];
   assign pes_pts_seen = pts_seen_q[ev.sid];
   assign pes_buf      = buf_q[ev.sid];

   // ***********************************************************
   // Packet rate terms, cross multiplied to avoid division
   // ***********************************************************
   // Interval ends at the next pack or at the end code arrival
   assign dt       = ev.val0 - scr_q;
   assign rate_due = pack_edge & have_pack_q & csps_q;
   assign thr      = restrict_q ? msc_pkg::THR_FLAG_HI : msc_pkg::THR_FLAG_LO;
   assign rmax     = msc_pkg::RMAX_MUL * msc_pkg::WIDE_W'(rate_bound_q);
   assign lim      = (rmax > thr) ? rmax : thr;
   assign lhs_d    = msc_pkg::WIDE_W'(np_q) * msc_pkg::SCR_HZ * thr;
   assign rhs_d    = msc_pkg::WIDE_W'(dt) * msc_pkg::PKT_PER_S * lim;

   // ***********************************************************
   // Clock ratio terms
   // ***********************************************************
   assign aud_nom = audio_hz(ev.aux[2:0]);
   assign aud_lhs = msc_pkg::RATIO_W'(ev.val0) * msc_pkg::RATIO_W'(aud_nom);
   assign aud_rhs = msc_pkg::SYS_CLK_HZ * msc_pkg::RATIO_W'(ev.val1);
   assign vid_rhs = msc_pkg::RATIO_W'(ticks_per_pic(ev.aux[2:0])) * msc_pkg::RATIO_W'(ev.val1);
   assign vid_lim = msc_pkg::TS_W'(ev.aux) + msc_pkg::VID_ADD_MAX;

   // ***********************************************************
   // Violation detection, one flag per constraint
   // ***********************************************************
   // Layer time stamps must match when the pairing demands it
   assign set_v[msc_pkg::V_LAYER]    = take & is_layer & ev.f_a & (ev.val0 != ev.val1);
   // Second I/P choice is barred under low delay
   assign set_v[msc_pkg::V_SPATIAL]  = take & is_spat & ((ev.aux[1:0] == msc_pkg::REF_ILLEGAL)
                                       | ((ev.aux[1:0] == msc_pkg::REF_SECOND_IP) & ev.f_a));
   // Next reference lies after, previous reference at or before
   assign set_v[msc_pkg::V_TEMPORAL] = take & is_temp & (ev.f_a ? (ev.val1 <= ev.val0)
                                                              : (ev.val1 > ev.val0));
   assign set_v[msc_pkg::V_BUFFLD]   = take & is_pes & ~ev.f_a
                                       & (~pes_seen | (pes_buf != ev.val1[msc_pkg::BUF_W-1:0]));
   assign set_v[msc_pkg::V_SYSFIRST] = pack_edge & first_pack_q & ~sys_first_q;
   assign set_v[msc_pkg::V_SYSPLACE] = take & is_sys & ~after_hdr_q;
   assign set_v[msc_pkg::V_SYSDIFF]  = take & is_sys & sys_valid_q & (ev.val0 != sys_val_q);
   assign set_v[msc_pkg::V_PKTRATE]  = (state_q == msc_pkg::ST_RATE) & (lhs_q > rhs_q);
   assign set_v[msc_pkg::V_AUDBUF]   = take & is_pes & csps_q & ev.f_a & ev.audio
                                       & (ev.val1 > msc_pkg::AUD_BUF_MAX);
   assign set_v[msc_pkg::V_VIDBUF]   = take & is_pes & csps_q & ev.f_a & ~ev.audio
                                       & (ev.val1 > vid_lim);
   assign set_v[msc_pkg::V_AUDCLK]   = take & is_aclk & ((aud_nom == 16'h0000) | (aud_lhs != aud_rhs));
   assign set_v[msc_pkg::V_VIDCLK]   = take & is_vclk & (msc_pkg::RATIO_W'(ev.val0) != vid_rhs);
   assign set_v[msc_pkg::V_FIRSTPTS] = take & is_pes & ev.f_c & ~pes_pts_seen & ~ev.f_b;
   // Unknown kinds, or stream content outside any pack
   assign set_v[msc_pkg::V_ORDER]    = take & (is_bad | ((is_pes | is_sys) & ~have_pack_q));

   // ***********************************************************
   // Sticky flags and sequencing
   // ***********************************************************
   // A set in the clearing cycle survives, so no event is lost
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         viol_q <= '0;
         done_q <= 1'b0;
      end else begin
         viol_q <= (viol_q & ~{msc_pkg::NVIOL{clear_viol}}) | set_v;
         done_q <= take;
      end
   end

   // Comparison runs one cycle after the pack edge to keep products off the compare path
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= msc_pkg::ST_IDLE;
         lhs_q   <= '0;
         rhs_q   <= '0;
      end else begin
         unique case (state_q)
            msc_pkg::ST_IDLE: begin
               state_q <= rate_due ? msc_pkg::ST_RATE : msc_pkg::ST_IDLE;
               lhs_q   <= rate_due ? lhs_d : lhs_q;
               rhs_q   <= rate_due ? rhs_d : rhs_q;
            end
            msc_pkg::ST_RATE: begin
               state_q <= msc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ***********************************************************
   // Pack and system header tracking
   // ***********************************************************
   // End code closes the stream; the next pack starts afresh
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         have_pack_q  <= 1'b0;
         first_pack_q <= 1'b0;
         sys_first_q  <= 1'b0;
         after_hdr_q  <= 1'b0;
         scr_q        <= '0;
         np_q         <= '0;
      end else if (take) begin
         have_pack_q  <= is_pack ? 1'b1 : (is_end ? 1'b0 : have_pack_q);
         first_pack_q <= is_pack ? ~have_pack_q : (is_end ? 1'b0 : first_pack_q);
         sys_first_q  <= (is_pack & ~have_pack_q) ? 1'b0 : (sys_first_q | (is_sys & first_pack_q));
         after_hdr_q  <= is_pack;
         scr_q        <= is_pack ? ev.val0 : scr_q;
         np_q         <= pack_edge ? '0 : (np_inc ? np_q + msc_pkg::NP_W'(1) : np_q);
      end
   end

   // First header of a stream fixes val0, which every later header in that stream must repeat
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sys_valid_q  <= 1'b0;
         sys_val_q    <= '0;
         csps_q       <= 1'b0;
         restrict_q   <= 1'b0;
         rate_bound_q <= '0;
      end else if (take & is_end) begin
         sys_valid_q  <= 1'b0;
      end else if (take & is_sys & ~sys_valid_q) begin
         sys_valid_q  <= 1'b1;
         sys_val_q    <= ev.val0;
         csps_q       <= ev.f_b;
         restrict_q   <= ev.f_a;
         rate_bound_q <= ev.aux[21:0];
      end
   end

   // ***********************************************************
   // Per stream buffer and time stamp history
   // ***********************************************************
   // Stream history is dropped at the end code so a new stream is checked from scratch
   for (genvar s = 0; s < NS; s++) begin : g_stream
      logic hit;
      assign hit = take & is_pes & (ev.sid == msc_pkg::SID_W'(s));

      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            seen_q[s]     <= 1'b0;
            pts_seen_q[s] <= 1'b0;
            buf_q[s]      <= '0;
         end else if (take & is_end) begin
            seen_q[s]     <= 1'b0;
            pts_seen_q[s] <= 1'b0;
         end else if (hit) begin
            seen_q[s]     <= seen_q[s] | ev.f_a;
            pts_seen_q[s] <= pts_seen_q[s] | ev.f_c;
            buf_q[s]      <= ev.f_a ? ev.val1[msc_pkg::BUF_W-1:0] : buf_q[s];
         end
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign viol = viol_q;
   assign csps = csps_q;
   assign done = done_q;

endmodule : msc_checker

/* File: msc_checker_assertions.sv */
`timescale 1ns/1ps
// ***********************************************************
// Port-level checks of the stream checker
// ***********************************************************
module msc_checker_assertions #(
   parameter int DEPTH = 16
) (
   input wire logic                      clk,
   input wire logic                      resetn,
   input wire logic                      ev_valid,
   input wire msc_pkg::msc_event_type    ev_data,
   input wire logic                      ev_ready,
   input wire logic                      clear_viol,
   input wire logic [msc_pkg::NVIOL-1:0] viol,
   input wire logic                      csps,
   input wire logic                      done
);
   localparam logic [msc_pkg::NVIOL-1:0] NO_RATE = 14'h3F7F;
   logic [7:0] backlog_q;
   logic       take;
   assign take = ev_valid && ev_ready;
   // Taken minus retired events; a retire with nothing owed means a phantom event
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         backlog_q <= 8'h00;
      end else begin
         backlog_q <= backlog_q + 8'(take) - 8'(done);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_ready_after_reset: assert property ($rose(resetn) |-> !ev_ready ##1 ev_ready)
      else $error("ev_ready did not rise one cycle after reset release");
   a_done_has_event: assert property (done |-> backlog_q != 8'h00)
      else $error("done without a taken event");
   a_backlog_bounded: assert property (backlog_q <= DEPTH + 2)
      else $error("more events owed than the buffer holds");
   a_viol_sticky: assert property (!$past(clear_viol) |-> (viol & $past(viol)) == $past(viol))
      else $error("violation flag fell without clear");
   a_clear_zeroes: assert property (clear_viol |=> done || $past(done) || viol == '0)
      else $error("flags not cleared");
   a_viol_with_done: assert property (|(viol & ~$past(viol) & NO_RATE) |-> done)
      else $error("flag rose without a retired event");
   a_rate_after_done: assert property ($rose(viol[msc_pkg::V_PKTRATE]) |-> $past(done))
      else $error("packet rate flag not one cycle after retire");
   a_csps_with_done: assert property ($changed(csps) |-> done || $past(done))
      else $error("constrained flag changed without an event");
   c_retire: cover property (done);
   c_rate: cover property ($rose(viol[msc_pkg::V_PKTRATE]));
   c_clear: cover property (clear_viol ##1 viol == '0);
endmodule : msc_checker_assertions
bind msc_checker msc_checker_assertions #(.DEPTH(DEPTH)) i_chk (.clk(clk), .resetn(resetn),
   .ev_valid(ev_valid), .ev_data(ev_data), .ev_ready(ev_ready), .clear_viol(clear_viol),
   .viol(viol), .csps(csps), .done(done));

/* File: msc_ev_src.sv */
`timescale 1ns/1ps
// ***********************************************************
// Stream producer: offers queued events with random stalls
// ***********************************************************
module msc_ev_src (
   input  wire logic              clk,
   output msc_pkg::msc_event_type ev_data,
   output logic                   ev_valid,
   input  wire logic              ev_ready
);
   msc_pkg::msc_event_type q[$];
   logic                   hit = 1'b0;
   initial ev_valid = 1'b0;
   initial ev_data = '0;
   // Note acceptance at the sampling edge, act on it at the falling edge
   always @(posedge clk) begin
      hit = ev_valid && ev_ready;
   end
   // An offer holds until taken; idle data is inverted so stale events never look valid
   always @(negedge clk) begin
      if (hit) begin
         void'(q.pop_front());
      end
      if (q.size() != 0 && ((ev_valid && !hit) || $urandom_range(3) != 0)) begin
         ev_valid <= 1'b1;
         ev_data  <= q[0];
      end else begin
         ev_valid <= 1'b0;
         ev_data  <= msc_pkg::msc_event_type'(~ev_data);
      end
   end
endmodule : msc_ev_src

/* File: msc_checker_tb.sv */
`timescale 1ns/1ps
module msc_checker_tb;
   logic                      clk = 1'b0;
   logic                      resetn = 1'b0;
   logic                      clear_viol = 1'b0;
   logic                      ev_valid, ev_ready, csps, done;
   msc_pkg::msc_event_type    ev_data;
   logic [msc_pkg::NVIOL-1:0] viol, exp_v, exp_t;
   logic [msc_pkg::NVIOL-1:0] exp_q[$];
   int                        num_errors = 0;
   int                        check_count = 0;
   int                        rnd;
   int                        ar[6] = '{16'h3E80, 16'h5622, 16'h5DC0, 16'h7D00, 16'hAC44, 16'hBB80};
   int                        vr[8] = '{24'h112EED, 24'h112A88, 24'h107AC0, 24'hDBF24, 24'hDBBA0,
                                        24'h83D60, 24'h6DF92, 24'h6DDD0};
   always #10 clk = ~clk;
   msc_ev_src i_src (.clk(clk), .ev_data(ev_data), .ev_valid(ev_valid), .ev_ready(ev_ready));
   msc_checker #(.DEPTH(16)) i_dut (.clk(clk), .resetn(resetn), .ev_valid(ev_valid), .ev_data(ev_data),
      .ev_ready(ev_ready), .clear_viol(clear_viol), .viol(viol), .csps(csps), .done(done));
   task automatic finish_test;
      if (num_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Queue one event and note the flags expected once it retires
   task automatic ev(input msc_pkg::msc_kind_type k, input int sid, input logic [3:0] fl, input longint v0,
                     input longint v1, input int aux, input logic [13:0] add);
      msc_pkg::msc_event_type e;
      e = '{k, 3'(sid), fl[3], fl[2], fl[1], fl[0], 33'(v0), 33'(v1), 24'(aux)};
      exp_v = exp_v | add;
      exp_q.push_back(exp_v);
      i_src.q.push_back(e);
   endtask : ev
   task automatic drain;
      for (int i = 0; i < 400 && exp_q.size() != 0; i++) begin
         @(negedge clk);
      end
      repeat (3) @(negedge clk);
      cmp(14'(exp_q.size()), 14'h0000);
   endtask : drain
   task automatic clear_all;
      drain();
      clear_viol = 1'b1;
      @(negedge clk);
      clear_viol = 1'b0;
      exp_v = '0;
      @(negedge clk);
      cmp(viol, 14'h0000);
   endtask : clear_all
   // Each retired event is judged against the oldest note; the rate flag lags and is masked
   always @(negedge clk) begin
      if (done === 1'b1) begin
         exp_t = 14'h3FFF;
         if (exp_q.size() != 0) begin
            exp_t = exp_q.pop_front();
         end
         cmp(viol & 14'h3F7F, exp_t & 14'h3F7F);
      end
   end
   // Watchdog sized well above the expected run of about a hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hA31E));
      exp_v = '0;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      ev(msc_pkg::EV_PACK, 0, 4'h0, 0, 0, 0, 14'h0000);
      ev(msc_pkg::EV_SYS, 0, 4'h6, 5, 0, 8'h64, 14'h0000);
      ev(msc_pkg::EV_PES, 0, 4'hF, 0, 16'h1000, 0, 14'h0000);
      ev(msc_pkg::EV_PES, 1, 4'h5, 0, 16'h7E8, 16'h3E8, 14'h1000);
      ev(msc_pkg::EV_PES, 0, 4'h8, 0, 16'hFA0, 0, 14'h0008);
      clear_all();
      ev(msc_pkg::EV_PES, 2, 4'hF, 0, 16'h1001, 0, 14'h0100);
      ev(msc_pkg::EV_PES, 3, 4'h7, 0, 16'h7E9, 16'h3E8, 14'h0200);
      ev(msc_pkg::EV_SYS, 0, 4'h6, 6, 0, 8'h64, 14'h0060);
      clear_all();
      for (int i = 0; i < 6; i++) ev(msc_pkg::EV_AUDCLK, 0, 4'h0, 28'h19BFCC0, ar[i], i, 14'h0000);
      ev(msc_pkg::EV_AUDCLK, 0, 4'h0, 28'h19BFCC0, 16'hBB81, 5, 14'h0400);
      for (int i = 0; i < 8; i++) ev(msc_pkg::EV_VIDCLK, 0, 4'h0, vr[i], 1, i, 14'h0000);
      ev(msc_pkg::EV_VIDCLK, 0, 4'h0, 24'h6DDD0, 1, 6, 14'h0800);
      for (int i = 0; i < 4; i++) begin
         rnd = $urandom;
         ev(msc_pkg::EV_LAYER, 0, 4'h4, rnd, rnd, 0, 14'h0000);
         ev(msc_pkg::EV_LAYER, 0, 4'h0, rnd, rnd + 1, 0, 14'h0000);
      end
      ev(msc_pkg::EV_LAYER, 0, 4'h4, 8'h0A, 8'h0B, 0, 14'h0001);
      for (int i = 0; i < 3; i++) ev(msc_pkg::EV_SPATIAL, 0, 4'h0, 0, 0, i, 14'h0000);
      ev(msc_pkg::EV_SPATIAL, 0, 4'h4, 0, 0, 2, 14'h0002);
      ev(msc_pkg::EV_TEMPORAL, 0, 4'h0, 8'h14, 8'h14, 0, 14'h0000);
      ev(msc_pkg::EV_TEMPORAL, 0, 4'h4, 8'h14, 8'h15, 0, 14'h0000);
      ev(msc_pkg::EV_TEMPORAL, 0, 4'h0, 8'h14, 8'h15, 0, 14'h0004);
      clear_all();
      ev(msc_pkg::EV_SPATIAL, 0, 4'h0, 0, 0, 3, 14'h0002);
      ev(msc_pkg::EV_END, 0, 4'h0, 28'h1000000, 0, 0, 14'h0000);
      ev(msc_pkg::EV_PACK, 0, 4'h0, 0, 0, 0, 14'h0000);
      ev(msc_pkg::EV_SYS, 0, 4'h6, 5, 0, 8'h64, 14'h0000);
      ev(msc_pkg::EV_PES, 4, 4'hF, 0, 8'h64, 0, 14'h0000);
      ev(msc_pkg::EV_PACK, 0, 4'h0, 12'h258, 0, 0, 14'h0000);
      drain();
      cmp({13'h0000, viol[msc_pkg::V_PKTRATE]}, 14'h0000);
      cmp({13'h0000, csps}, 14'h0001);
      ev(msc_pkg::EV_PES, 4, 4'h8, 0, 8'h64, 0, 14'h0000);
      ev(msc_pkg::EV_PACK, 0, 4'h0, 12'h383, 0, 0, 14'h0000);
      drain();
      cmp({13'h0000, viol[msc_pkg::V_PKTRATE]}, 14'h0001);
      finish_test();
   end
endmodule : msc_checker_tb
